// file: verilog/ssd_spi.sv
`timescale 1ns/10ps
// How it works
// - Completed byte sets done flag, bit 7; interrupt when enabled.
// - Done flag clears after status read then data read or write.
// - Data writes ignored while done flag set and status unread.
// - Data write during an active shift sets collision flag, bit 6.
// - Byte finishing while done flag set raises overrun, bit 5.
// - Overrun clears when software reads the status register.
// - Select low in master mode sets fault flag, bit 4.
// - Fault clears after status read with fault set, then control write.
// - Output disable bit 2 releases data output; else driven if enabled, in slave mode only while selected.
// - Soft select manage bit 1 replaces pin select by level bit.
// - Soft select level zero selects, one deselects.
// - In master mode a permitted data write with no byte shifting starts a new byte.
// - Last clock copies shift register to receive buffer unless done flag still set; reads see it.
// - Permitted data write loads the transmit shifter directly in master mode; in slave mode it loads tx_hold.
// - Data at 21h, control at 22h, control/status at 23h.
// - Enabled interrupt follows done, fault or overrun flag.
// - Master fault clears enable and master bits.
module ssd_spi (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ssd_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic ss_in_n
);

  // ****************************************************
  // Register bus
  // ****************************************************
  logic [7:0] ctrl;
  logic transfer_done_flag;
  logic write_collision_flag;
  logic overrun_flag;
  logic master_fault_flag;
  logic serial_output_disable;
  logic soft_select_manage;
  logic soft_select_level;
  logic [7:0] rx_buf;
  logic [31:0] rd_q;
  logic csr_seen;
  logic master_fault_flag_armed;
  logic setup_ph;
  logic access_ph;
  logic hit_data;
  logic hit_ctrl;
  logic hit_csr;
  logic data_acc;
  logic data_wr;
  logic ctrl_wr;
  logic csr_wr;
  logic csr_rd;
  logic wr_ok;
  logic xfer_busy;
  logic done_evt;
  logic [7:0] done_byte;
  logic fault_cond;
  logic [7:0] csr_val;

  // Decode; zero wait states, error on any other address
  // register decode
  assign hit_data = paddr == ssd_pkg::ADDR_DATA;
  assign hit_ctrl = paddr == ssd_pkg::ADDR_CTRL;
  assign hit_csr = paddr == ssd_pkg::ADDR_CSR;
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign pready = 1'b1;
  assign pslverr = access_ph & ~(hit_data | hit_ctrl | hit_csr);
  assign prdata = rd_q;
  assign data_acc = access_ph & hit_data;
  assign data_wr = data_acc & pwrite;
  assign ctrl_wr = access_ph & hit_ctrl & pwrite;
  assign csr_wr = access_ph & hit_csr & pwrite;
  assign csr_rd = access_ph & hit_csr & ~pwrite;
  // writes held off until status read
  assign wr_ok = ~transfer_done_flag | csr_seen;

  assign csr_val = {transfer_done_flag, write_collision_flag, overrun_flag,
                    master_fault_flag, 1'b0, serial_output_disable,
                    soft_select_manage, soft_select_level};

  // Read data captured in setup so it is a flop at the access edge.
  // Overrun and fault clears act only on bits software actually saw.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_q <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      if (hit_data) begin
        rd_q <= {24'h00_0000, rx_buf};
      end else if (hit_ctrl) begin
        rd_q <= {24'h00_0000, ctrl};
      end else if (hit_csr) begin
        rd_q <= {24'h00_0000, csr_val};
      end else begin
        rd_q <= 32'h0000_0000;
      end
    end
  end

  // Control register; master fault drops enable and master
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= ssd_pkg::CTL_RESET;
    end else if (fault_cond) begin
      ctrl[ssd_pkg::CTL_ENABLE] <= 1'b0;
      ctrl[ssd_pkg::CTL_MASTER] <= 1'b0;
    end else if (ctrl_wr) begin
      ctrl <= pwdata[7:0];
    end
  end

  // Writable configuration bits of the status register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      {serial_output_disable, soft_select_manage, soft_select_level} <=
        ssd_pkg::CSR_CFG_RESET;
    end else if (csr_wr) begin
      serial_output_disable <= pwdata[ssd_pkg::CSR_SOD];
      soft_select_manage <= pwdata[ssd_pkg::CSR_SSM];
      soft_select_level <= pwdata[ssd_pkg::CSR_SSI];
    end
  end

  // First step of the clear sequences
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      csr_seen <= 1'b0;
    end else if (csr_rd) begin
      csr_seen <= 1'b1;
    end else if (data_acc) begin
      csr_seen <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      master_fault_flag_armed <= 1'b0;
    end else if (csr_rd && rd_q[ssd_pkg::CSR_MASTER_FAULT_FLAG]) begin
      master_fault_flag_armed <= 1'b1;
    end else if (ctrl_wr) begin
      master_fault_flag_armed <= 1'b0;
    end
  end

  // Done flag; a new completion beats a clear in the same cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      transfer_done_flag <= 1'b0;
    end else if (done_evt) begin
      transfer_done_flag <= 1'b1;
    end else if (data_acc && csr_seen) begin
      transfer_done_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      write_collision_flag <= 1'b0;
    end else if (data_wr && xfer_busy) begin
      write_collision_flag <= 1'b1;
    end else if (data_acc && csr_seen) begin
      write_collision_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      overrun_flag <= 1'b0;
    end else if (done_evt && transfer_done_flag) begin
      // byte lands on an unread buffer
      overrun_flag <= 1'b1;
    end else if (csr_rd && rd_q[ssd_pkg::CSR_OVR]) begin
      overrun_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      master_fault_flag <= 1'b0;
    end else if (fault_cond) begin
      master_fault_flag <= 1'b1;
    end else if (ctrl_wr && master_fault_flag_armed) begin
      master_fault_flag <= 1'b0;
    end
  end

  // Receive buffer keeps the old byte on overrun
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_buf <= 8'h00;
    end else if (done_evt && !transfer_done_flag) begin
      rx_buf <= done_byte;
    end
  end

  assign irq = ctrl[ssd_pkg::CTL_IRQ_EN] &
               (transfer_done_flag | master_fault_flag | overrun_flag);

  // ****************************************************
  // Select and pin synchronisers
  // ****************************************************
  logic ss_s1;
  logic ss_s2;
  logic miso_s1;
  logic miso_s2;
  logic sel_n;
  logic is_master;
  logic enabled;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ss_s1 <= 1'b1;
      ss_s2 <= 1'b1;
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
    end else begin
      ss_s1 <= ss_in_n;
      ss_s2 <= ss_s1;
      miso_s1 <= miso_in;
      miso_s2 <= miso_s1;
    end
  end

  assign sel_n = soft_select_manage ? soft_select_level : ss_s2;
  assign enabled = ctrl[ssd_pkg::CTL_ENABLE];
  assign is_master = ctrl[ssd_pkg::CTL_MASTER];
  assign fault_cond = enabled & is_master & ~sel_n;

  // ****************************************************
  // Master engine (mode 0 timing, polarity applied at pin)
  // ****************************************************
  logic mst_busy;
  logic [6:0] mst_cnt;
  logic [3:0] mst_edges;
  logic [7:0] mst_shift;
  logic sck_lvl;
  logic [6:0] half;
  logic mst_tick;
  logic mst_start;
  logic mst_done;

  // Rate code to half period
  always_comb begin
    case ({ctrl[ssd_pkg::CTL_SPR2], ctrl[ssd_pkg::CTL_SPR1],
           ctrl[ssd_pkg::CTL_SPR0]})
      3'h4: half = ssd_pkg::HALF_DIV4;
      3'h0: half = ssd_pkg::HALF_DIV8;
      3'h1: half = ssd_pkg::HALF_DIV16;
      3'h6: half = ssd_pkg::HALF_DIV32;
      3'h2: half = ssd_pkg::HALF_DIV64;
      3'h3: half = ssd_pkg::HALF_DIV128;
      default: half = ssd_pkg::HALF_DIV8;
    endcase
  end

  // data write starts a master byte
  assign mst_start = data_wr & wr_ok & ~xfer_busy & enabled & is_master;
  assign mst_tick = mst_busy & (mst_cnt == half - 7'h01);
  assign mst_done = mst_tick & (mst_edges == ssd_pkg::LAST_EDGE);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mst_busy <= 1'b0;
      mst_cnt <= 7'h00;
      mst_edges <= 4'h0;
      sck_lvl <= 1'b0;
    end else if (mst_start) begin
      mst_busy <= 1'b1;
      mst_cnt <= 7'h00;
      mst_edges <= 4'h0;
      sck_lvl <= 1'b0;
    end else if (!enabled || !is_master) begin
      // Fault or disable aborts a byte without completing it
      mst_busy <= 1'b0;
      sck_lvl <= 1'b0;
    end else if (mst_tick) begin
      mst_cnt <= 7'h00;
      mst_edges <= mst_edges + 4'h1;
      sck_lvl <= ~sck_lvl;
      if (mst_done) begin
        mst_busy <= 1'b0;
      end
    end else if (mst_busy) begin
      mst_cnt <= mst_cnt + 7'h01;
    end
  end

  // write goes straight into the shifter
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mst_shift <= 8'h00;
    end else if (mst_start) begin
      mst_shift <= pwdata[7:0];
    end else if (mst_tick && sck_lvl) begin
      // Taken at the closing edge: the two-flop delay puts the sample
      // near the opening edge, so the fastest rate still sees a settled bit
      mst_shift <= {mst_shift[6:0], miso_s2};
    end
  end

  assign sck_out = sck_lvl ^ ctrl[ssd_pkg::CTL_CPOL];
  assign sck_oe = enabled & is_master;
  assign mosi_out = mst_shift[7];
  assign mosi_oe = enabled & is_master & ~serial_output_disable;

  // ****************************************************
  // Slave engine on the link clock
  // ****************************************************
  logic [7:0] tx_hold;
  logic [2:0] l_cnt;
  logic [7:0] l_shift;
  logic [7:0] l_rx;
  logic l_start_tgl;
  logic l_done_tgl;
  logic l_miso;
  logic l_sel_n;
  logic l_en;
  logic [2:0] st_sync;
  logic [2:0] dn_sync;
  logic slv_busy;
  logic slv_start;
  logic slv_done;

  // Slave transmit byte; held steady while the link shifts it out
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_hold <= 8'h00;
    end else if (data_wr && wr_ok && !xfer_busy && !is_master) begin
      tx_hold <= pwdata[7:0];
    end
  end

  // Config bits are static while a frame runs, so read directly
  assign l_sel_n = soft_select_manage ? soft_select_level : ss_in_n;
  assign l_en = enabled & ~is_master & ~l_sel_n;

  always_ff @(posedge sck_in or negedge nrst) begin
    if (!nrst) begin
      l_cnt <= 3'h0;
      l_shift <= 8'h00;
      l_rx <= 8'h00;
      l_start_tgl <= 1'b0;
      l_done_tgl <= 1'b0;
    end else if (l_en) begin
      l_cnt <= l_cnt + 3'h1;
      l_shift <= {l_shift[6:0], mosi_in};
      if (l_cnt == 3'h0) begin
        l_start_tgl <= ~l_start_tgl;
      end
      if (l_cnt == ssd_pkg::LAST_BIT) begin
        l_rx <= {l_shift[6:0], mosi_in};
        l_done_tgl <= ~l_done_tgl;
      end
    end
  end

  // Next bit changes on the falling edge, away from sampling
  always_ff @(negedge sck_in or negedge nrst) begin
    if (!nrst) begin
      l_miso <= 1'b0;
    end else begin
      l_miso <= tx_hold[ssd_pkg::LAST_BIT - l_cnt];
    end
  end

  assign miso_out = (l_cnt == 3'h0) ? tx_hold[7] : l_miso;
  // slave output only when enabled and selected
  assign miso_oe = enabled & ~is_master & ~serial_output_disable & ~sel_n;

  // Toggle crossings back to ref_clk
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_sync <= 3'h0;
      dn_sync <= 3'h0;
    end else begin
      st_sync <= {st_sync[1:0], l_start_tgl};
      dn_sync <= {dn_sync[1:0], l_done_tgl};
    end
  end

  assign slv_start = st_sync[2] ^ st_sync[1];
  assign slv_done = dn_sync[2] ^ dn_sync[1];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      slv_busy <= 1'b0;
    end else if (slv_done) begin
      slv_busy <= 1'b0;
    end else if (slv_start) begin
      slv_busy <= 1'b1;
    end
  end

  assign xfer_busy = mst_busy | slv_busy;
  assign done_evt = mst_done | slv_done;
  // l_rx is stable for most of a byte after its toggle lands
  assign done_byte = mst_done ? {mst_shift[6:0], miso_s2} : l_rx;

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_done_sets_flag: assert property (done_evt |=> transfer_done_flag)
    else $error("done flag not set after byte");
  a_done_clear_seq: assert property (
    $fell(transfer_done_flag) |-> $past(data_acc && csr_seen))
    else $error("done flag cleared without sequence");
  a_write_blocked: assert property (
    data_wr && transfer_done_flag && !csr_seen && !mst_busy |=> !mst_busy)
    else $error("inhibited write started a byte");
  a_write_collision_flag_on_busy: assert property (data_wr && xfer_busy |=>
    write_collision_flag) else $error("collision not flagged");
  a_ovr_on_full: assert property (done_evt && transfer_done_flag |=>
    overrun_flag && $stable(rx_buf)) else $error("overrun mishandled");
  a_ovr_clear: assert property ($fell(overrun_flag) |->
    $past(csr_rd)) else $error("overrun cleared without status read");
  a_fault_set: assert property (fault_cond |=> master_fault_flag &&
    !ctrl[ssd_pkg::CTL_ENABLE] && !ctrl[ssd_pkg::CTL_MASTER])
    else $error("fault did not disable master");
  a_fault_clear: assert property ($fell(master_fault_flag) |->
    $past(ctrl_wr && master_fault_flag_armed)) else $error("fault cleared early");
  a_out_release: assert property (serial_output_disable |->
    !mosi_oe && !miso_oe) else $error("output driven while disabled");
  a_master_start: assert property (mst_start |=> mst_busy &&
    mst_shift == $past(pwdata[7:0])) else $error("master did not start");
  a_rx_copy: assert property (done_evt && !transfer_done_flag |=>
    rx_buf == $past(done_byte)) else $error("buffer not loaded");

  c_master_byte: cover property (mst_start ##[1:1000] mst_done);
  c_overrun: cover property (done_evt && transfer_done_flag);
  c_fault: cover property (fault_cond);
  c_collision: cover property (data_wr && xfer_busy);

endmodule // ssd_spi

// file: verilog/ssd_pkg.sv
// ****************************************************
// Shared constants for the serial status/data block
// ****************************************************
package ssd_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_DATA = 8'h21;
  localparam logic [7:0] IDX_CTRL = 8'h22;
  localparam logic [7:0] IDX_CSR = 8'h23;
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_DATA = {2'h0, IDX_DATA, 2'h0};
  localparam logic [11:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_CSR = {2'h0, IDX_CSR, 2'h0};

  // Control register fields
  localparam int CTL_IRQ_EN = 7;
  localparam int CTL_ENABLE = 6;
  localparam int CTL_SPR2 = 5;
  localparam int CTL_MASTER = 4;
  localparam int CTL_CPOL = 3;
  localparam int CTL_SPR1 = 1;
  localparam int CTL_SPR0 = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // Control/status register fields
  localparam int CSR_DONE = 7;
  localparam int CSR_WRITE_COLLISION_FLAG = 6;
  localparam int CSR_OVR = 5;
  localparam int CSR_MASTER_FAULT_FLAG = 4;
  localparam int CSR_RSVD = 3;
  localparam int CSR_SOD = 2;
  localparam int CSR_SSM = 1;
  localparam int CSR_SSI = 0;
  localparam logic [2:0] CSR_CFG_RESET = 3'h0;

  // Master half-period in ref_clk cycles per rate code {spr2,spr1,spr0}
  localparam logic [6:0] HALF_DIV4 = 7'h02;
  localparam logic [6:0] HALF_DIV8 = 7'h04;
  localparam logic [6:0] HALF_DIV16 = 7'h08;
  localparam logic [6:0] HALF_DIV32 = 7'h10;
  localparam logic [6:0] HALF_DIV64 = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;
  localparam logic [3:0] LAST_EDGE = 4'hF;
  localparam logic [2:0] LAST_BIT = 3'h7;
endpackage

// file: verification/ssd_peer.sv
`timescale 1ns/10ps
// ************************************************************
// Far-side serial device: slave to our master, master to our slave
// ************************************************************
module ssd_peer (
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic mosi_out,
  input wire logic miso_out,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  output logic sck_in,
  output logic mosi_in,
  output logic miso_in,
  output logic ss_in_n
);
  logic [7:0] sr;
  logic [7:0] cap;

  // Released reply line shows the inverse bit, never a stale copy
  assign miso_in = sck_oe ? sr[7] : ~sr[7];

  // Link idles low, select pulled high
  initial begin
    sck_in = 1'b0;
    mosi_in = 1'b0;
    ss_in_n = 1'b1;
    sr = 8'h00;
    cap = 8'h00;
  end

  // Take master bits on the rising clock
  always @(posedge sck_out) begin
    if (sck_oe) cap <= {cap[6:0], mosi_oe ? mosi_out : ~mosi_out};
  end

  // Next reply bit after the falling clock
  always @(negedge sck_out) begin
    if (sck_oe) sr <= {sr[6:0], 1'b0};
  end

  // Preset the reply byte
  task automatic load(input logic [7:0] b);
    sr = b;
  endtask

  // One byte as link master; clock runs only inside the frame
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    // Select leads the clock long enough for the block's select sync
    ss_in_n = 1'b0;
    #200;
    for (int i = 7; i >= 0; i--) begin
      mosi_in = tx[i];
      #32 sck_in = 1'b1;
      // Undriven reply line reads as the inverse bit
      rx[i] = miso_oe ? miso_out : ~miso_out;
      #32 sck_in = 1'b0;
    end
    #40 ss_in_n = 1'b1;
    mosi_in = ~mosi_in;
  endtask

  // Pull select low while our block is master
  task automatic fault();
    ss_in_n = 1'b0;
    #500 ss_in_n = 1'b1;
  endtask
endmodule // ssd_peer

// file: verification/spi_status_data_regs_test.sv
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, (g), (e)); end end
// ************************************************************
// Self-checking bench for the serial status/data block
// ************************************************************
module spi_status_data_regs_test;
  logic ref_clk = 1'b0;
  logic nrst;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, sck_in, sck_out, sck_oe;
  logic mosi_in, mosi_out, mosi_oe, miso_in, miso_out, miso_oe, ss_in_n;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] q, r;
  logic e;

  always #25 ref_clk = ~ref_clk;

  ssd_spi ssd_spi_i (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
    .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
    .miso_in(miso_in), .miso_out(miso_out), .miso_oe(miso_oe),
    .ss_in_n(ss_in_n));

  ssd_peer ssd_peer_i (.sck_out(sck_out), .sck_oe(sck_oe),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_out(miso_out),
    .miso_oe(miso_oe), .sck_in(sck_in),
    .mosi_in(mosi_in), .miso_in(miso_in), .ss_in_n(ss_in_n));

  // One APB transfer; waits on pready, results settle by the falling edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] d, output logic [7:0] rq,
                     output logic er);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rq = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] x;
    logic y;
    apb(1'b1, a, d, x, y);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] x;
    logic y;
    apb(1'b0, a, 8'h00, x, y);
    `CHK(x, exp)
  endtask

  // Bounded wait for the shared interrupt line
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  task automatic t_reset();
    rd_chk(ssd_pkg::ADDR_CTRL, 8'h00);
    rd_chk(ssd_pkg::ADDR_CSR, 8'h00);
    rd_chk(ssd_pkg::ADDR_DATA, 8'h00);
    apb(1'b0, 12'h090, 8'h00, q, e);
    `CHK(e, 1'b1)
    $display("t_reset finished");
  endtask

  task automatic t_select();
    wr(ssd_pkg::ADDR_CTRL, 8'h40);
    wr(ssd_pkg::ADDR_CSR, 8'h02);
    `CHK(miso_oe, 1'b1)
    wr(ssd_pkg::ADDR_CSR, 8'h03);
    `CHK(miso_oe, 1'b0)
    // Reserved bit kept at zero by software
    wr(ssd_pkg::ADDR_CSR, 8'h06);
    rd_chk(ssd_pkg::ADDR_CSR, 8'h06);
    `CHK(miso_oe, 1'b0)
    wr(ssd_pkg::ADDR_CSR, 8'h03);
    wr(ssd_pkg::ADDR_CTRL, 8'h50);
    `CHK(mosi_oe, 1'b1)
    wr(ssd_pkg::ADDR_CSR, 8'h07);
    `CHK(mosi_oe, 1'b0)
    wr(ssd_pkg::ADDR_CSR, 8'h03);
    wr(ssd_pkg::ADDR_CTRL, 8'h10);
    `CHK(mosi_oe, 1'b0)
    wr(ssd_pkg::ADDR_CTRL, 8'h00);
    wr(ssd_pkg::ADDR_CSR, 8'h00);
    $display("t_select finished");
  endtask

  task automatic t_master();
    ssd_peer_i.load(8'h3C);
    wr(ssd_pkg::ADDR_CTRL, 8'hD0);
    wr(ssd_pkg::ADDR_DATA, 8'hA5);
    wr(ssd_pkg::ADDR_DATA, 8'h77);
    wait_irq();
    `CHK(irq, 1'b1)
    // Done set and status unread: this write must not start a byte
    wr(ssd_pkg::ADDR_DATA, 8'h11);
    repeat (80) @(negedge ref_clk);
    `CHK(ssd_peer_i.cap, 8'hA5)
    rd_chk(ssd_pkg::ADDR_CSR, 8'hC0);
    rd_chk(ssd_pkg::ADDR_DATA, 8'h3C);
    rd_chk(ssd_pkg::ADDR_CSR, 8'h00);
    `CHK(irq, 1'b0)
    wr(ssd_pkg::ADDR_DATA, 8'h5E);
    wait_irq();
    `CHK(ssd_peer_i.cap, 8'h5E)
    rd_chk(ssd_pkg::ADDR_CSR, 8'h80);
    rd_chk(ssd_pkg::ADDR_DATA, 8'h00);
    // Fastest rate: reply bits must survive the input synchroniser
    ssd_peer_i.load(8'h69);
    wr(ssd_pkg::ADDR_CTRL, 8'hF0);
    wr(ssd_pkg::ADDR_DATA, 8'hC6);
    wait_irq();
    `CHK(ssd_peer_i.cap, 8'hC6)
    rd_chk(ssd_pkg::ADDR_CSR, 8'h80);
    rd_chk(ssd_pkg::ADDR_DATA, 8'h69);
    wr(ssd_pkg::ADDR_CTRL, 8'h00);
    $display("t_master finished");
  endtask

  task automatic t_fault();
    wr(ssd_pkg::ADDR_CTRL, 8'hD0);
    ssd_peer_i.fault();
    repeat (4) @(negedge ref_clk);
    `CHK(irq, 1'b1)
    rd_chk(ssd_pkg::ADDR_CTRL, 8'h80);
    wr(ssd_pkg::ADDR_CTRL, 8'h80);
    `CHK(irq, 1'b1)
    rd_chk(ssd_pkg::ADDR_CSR, 8'h10);
    wr(ssd_pkg::ADDR_CTRL, 8'h00);
    rd_chk(ssd_pkg::ADDR_CSR, 8'h00);
    `CHK(irq, 1'b0)
    $display("t_fault finished");
  endtask

  task automatic t_slave();
    wr(ssd_pkg::ADDR_CTRL, 8'hC0);
    wr(ssd_pkg::ADDR_DATA, 8'h96);
    ssd_peer_i.xfer(8'h5A, r);
    repeat (4) @(negedge ref_clk);
    `CHK(r, 8'h96)
    `CHK(irq, 1'b1)
    // Second byte lands before software clears the first
    ssd_peer_i.xfer(8'hC3, r);
    repeat (4) @(negedge ref_clk);
    rd_chk(ssd_pkg::ADDR_CSR, 8'hA0);
    rd_chk(ssd_pkg::ADDR_CSR, 8'h80);
    rd_chk(ssd_pkg::ADDR_DATA, 8'h5A);
    rd_chk(ssd_pkg::ADDR_CSR, 8'h00);
    wr(ssd_pkg::ADDR_CTRL, 8'h00);
    $display("t_slave finished");
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles; this leaves ample margin
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      $display("[ERR] %0t run timed out", $time);
      conclude();
    end
  end

  // Main sequence
  initial begin
    // Driven from unknown so every asynchronous reset sees an edge
    nrst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_select();
    t_master();
    t_fault();
    t_slave();
    conclude();
  end
endmodule // spi_status_data_regs_test
